// file: logic/nsr_host_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Without a latched write, accesses stay blocked until the requester releases busy.
// - Software store: six reads 4E38,B1C7,83E0,7C1F,703F,8FC0 in that order.
// - Any other read or write inside a sequence aborts it.
// - Software recall: same five reads, then a read at 4C63.
// - Power-loss store disable: same five reads, then chip-select read at 8B45.
// - Power-loss store enable: same five reads, then chip-select read at 4B46.
// - Host keeps write enable high through all six sequence reads.
// - After changing power-loss store setting, host issues a store to keep it; the controller only sets the unsaved status bit.
module nsr_host_ctrl #(
	parameter int ACCESS_CYC_P      = nsr_pkg::ACCESS_CYC,
	parameter int RECOVER_CYC_P     = nsr_pkg::RECOVER_CYC,
	parameter int START_DELAY_CYC_P = nsr_pkg::START_DELAY_CYC,
	parameter int HOLD_CYC_P        = nsr_pkg::POST_BUSY_HOLD_CYC,
	parameter int PULSE_CYC_P       = nsr_pkg::REQUEST_PULSE_CYC
) (
	// clock, reset, enable
	input  wire logic                          CLK_IN,
	input  wire logic                          RESET_N_IN,
	input  wire logic                          CLK_EN_IN,
	// avalon-mm slave
	input  wire logic [2:0]                    AVS_ADDRESS_IN,
	input  wire logic                          AVS_READ_IN,
	input  wire logic                          AVS_WRITE_IN,
	input  wire logic [31:0]                   AVS_WRITEDATA_IN,
	output logic      [31:0]                   AVS_READDATA_OUT,
	output logic                               AVS_WAITREQUEST_OUT,
	// sram pins
	output nsr_pkg::nsr_sram_out_t             SRAM_PINS_OUT,
	input  wire logic [nsr_pkg::DATA_W-1:0]    DQ_IN,
	// open-drain busy / store request pin
	input  wire logic                          STORE_BUSY_N_IN,
	output logic                               STORE_BUSY_N_OUT,
	output logic                               STORE_BUSY_N_OE_OUT
);
	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	initial begin
		if (ACCESS_CYC_P < 3 || RECOVER_CYC_P < 1 || START_DELAY_CYC_P < 1 || HOLD_CYC_P < 1 ||
			PULSE_CYC_P < 1 || ACCESS_CYC_P >= 2**nsr_pkg::CNT_W || START_DELAY_CYC_P >= 2**nsr_pkg::CNT_W)
			$error("nsr_host_ctrl: timing parameter out of range");
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	typedef logic [nsr_pkg::CNT_W-1:0] cnt_t;
	localparam cnt_t ACC_C = cnt_t'(ACCESS_CYC_P - 1);
	localparam cnt_t GAP_C = cnt_t'(RECOVER_CYC_P - 1);
	localparam cnt_t DLY_C = cnt_t'(START_DELAY_CYC_P - 1);
	localparam cnt_t HLD_C = cnt_t'(HOLD_CYC_P - 1);
	localparam cnt_t PLS_C = cnt_t'(PULSE_CYC_P - 1);
	nsr_pkg::nsr_state_t     state_ff, nxt_state;
	cnt_t                    cnt_ff, nxt_cnt;
	logic [2:0]              idx_ff, nxt_idx;
	logic [2:0]              cmd_ff;
	logic [nsr_pkg::ADDR_W-1:0] addr_ff;
	logic [nsr_pkg::DATA_W-1:0] wdata_ff, rdata_ff;
	logic [1:0]              be_ff;
	logic                    ack_ff, done_ff, pls_en_ff, unsaved_ff;
	logic                    busy_m_ff, busy_s_ff;
	logic [nsr_pkg::DATA_W-1:0] dq_m_ff, dq_s_ff;
	logic                    cmd_go, is_seq, is_cmd_wr;
	nsr_pkg::nsr_sram_out_t  pins_ff, nxt_pins;

	// sequence address for a step of a command
	function automatic logic [15:0] seq_addr(input logic [2:0] idx, input logic [2:0] cmd);
		case (idx)
			3'h0: seq_addr = nsr_pkg::SEQ_A0;
			3'h1: seq_addr = nsr_pkg::SEQ_A1;
			3'h2: seq_addr = nsr_pkg::SEQ_A2;
			3'h3: seq_addr = nsr_pkg::SEQ_A3;
			3'h4: seq_addr = nsr_pkg::SEQ_A4;
			default: case (cmd)
				nsr_pkg::CMD_SW_RECALL:   seq_addr = nsr_pkg::FIN_RECALL;
				nsr_pkg::CMD_PLS_DISABLE: seq_addr = nsr_pkg::FIN_DISABLE;
				nsr_pkg::CMD_PLS_ENABLE:  seq_addr = nsr_pkg::FIN_ENABLE;
				default:                  seq_addr = nsr_pkg::FIN_STORE;
			endcase
		endcase
	endfunction : seq_addr

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			busy_m_ff <= 1'b1;
			busy_s_ff <= 1'b1;
			dq_m_ff   <= '0;
			dq_s_ff   <= '0;
		end else if (CLK_EN_IN) begin
			busy_m_ff <= STORE_BUSY_N_IN;
			busy_s_ff <= busy_m_ff;
			dq_m_ff   <= DQ_IN;
			dq_s_ff   <= dq_m_ff;
		end
	end

	// ----------------------------------------
	// avalon slave
	// ----------------------------------------
	assign is_cmd_wr = AVS_WRITE_IN && AVS_ADDRESS_IN == nsr_pkg::REG_CMD;
	assign cmd_go    = is_cmd_wr && !ack_ff && state_ff == nsr_pkg::S_IDLE && busy_s_ff && CLK_EN_IN;
	assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_ff;

	// one wait cycle per access; command write stalls while the engine runs
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ack_ff           <= 1'b0;
			AVS_READDATA_OUT <= '0;
			addr_ff          <= '0;
			wdata_ff         <= '0;
			be_ff            <= 2'h3;
			cmd_ff           <= '0;
		end else if (CLK_EN_IN) begin
			ack_ff <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_ff && (!is_cmd_wr || cmd_go);
			if (AVS_READ_IN && !ack_ff) begin
				case (AVS_ADDRESS_IN)
					nsr_pkg::REG_ADDR:   AVS_READDATA_OUT <= 32'(addr_ff);
					nsr_pkg::REG_WDATA:  AVS_READDATA_OUT <= {14'h0000, be_ff, wdata_ff};
					nsr_pkg::REG_RDATA:  AVS_READDATA_OUT <= 32'(rdata_ff);
					nsr_pkg::REG_STATUS: AVS_READDATA_OUT <= {27'h0000000, unsaved_ff, pls_en_ff, done_ff,
						busy_s_ff, state_ff != nsr_pkg::S_IDLE};
					default:             AVS_READDATA_OUT <= 32'h00000000;
				endcase
			end
			if (AVS_WRITE_IN && !ack_ff && AVS_ADDRESS_IN == nsr_pkg::REG_ADDR)
				addr_ff <= AVS_WRITEDATA_IN[nsr_pkg::ADDR_W-1:0];
			if (AVS_WRITE_IN && !ack_ff && AVS_ADDRESS_IN == nsr_pkg::REG_WDATA) begin
				wdata_ff <= AVS_WRITEDATA_IN[nsr_pkg::DATA_W-1:0];
				be_ff    <= AVS_WRITEDATA_IN[nsr_pkg::WDATA_BE_POS+:2];
			end
			if (cmd_go)
				cmd_ff <= AVS_WRITEDATA_IN[2:0];
		end
	end

	// ----------------------------------------
	// access engine
	// ----------------------------------------
	assign is_seq = cmd_ff >= nsr_pkg::CMD_SW_STORE && cmd_ff <= nsr_pkg::CMD_PLS_ENABLE;

	// next state, counter and sequence step
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_idx   = idx_ff;
		case (state_ff)
			nsr_pkg::S_IDLE: begin
				nxt_idx = 3'h0;
				if (!busy_s_ff) begin
					nxt_state = nsr_pkg::S_WAIT;
					nxt_cnt   = '0;
				end else if (cmd_go && AVS_WRITEDATA_IN[2:0] == nsr_pkg::CMD_HW_STORE) begin
					nxt_state = nsr_pkg::S_PULL;
					nxt_cnt   = PLS_C;
				end else if (cmd_go && AVS_WRITEDATA_IN[2:0] != 3'h0) begin
					nxt_state = nsr_pkg::S_ACC;
					nxt_cnt   = ACC_C;
				end
			end
			nsr_pkg::S_ACC: begin
				nxt_cnt = cnt_ff - cnt_t'(1);
				if (cnt_ff == '0) begin
					nxt_state = nsr_pkg::S_GAP;
					nxt_cnt   = GAP_C;
				end
			end
			nsr_pkg::S_GAP: begin
				nxt_cnt = cnt_ff - cnt_t'(1);
				if (cnt_ff == '0) begin
					if (is_seq && idx_ff != nsr_pkg::SEQ_LAST) begin
						nxt_state = nsr_pkg::S_ACC;
						nxt_cnt   = ACC_C;
						nxt_idx   = idx_ff + 3'h1;
					end else if (is_seq) begin
						nxt_state = nsr_pkg::S_WAIT;
						nxt_cnt   = DLY_C;
					end else begin
						nxt_state = nsr_pkg::S_IDLE;
					end
				end
			end
			nsr_pkg::S_PULL: begin
				nxt_cnt = cnt_ff - cnt_t'(1);
				if (cnt_ff == '0) begin
					nxt_state = nsr_pkg::S_WAIT;
					nxt_cnt   = DLY_C;
				end
			end
			nsr_pkg::S_WAIT: begin
				if (cnt_ff != '0)
					nxt_cnt = cnt_ff - cnt_t'(1);
				else if (busy_s_ff) begin
					nxt_state = nsr_pkg::S_HOLD;
					nxt_cnt   = HLD_C;
				end
			end
			nsr_pkg::S_HOLD: begin
				nxt_cnt = cnt_ff - cnt_t'(1);
				if (cnt_ff == '0)
					nxt_state = nsr_pkg::S_IDLE;
			end
			default: nxt_state = nsr_pkg::S_IDLE;
		endcase
	end

	// registered pin values for the next state; a new command decides its own first cycle,
	// so a write after a sequence never starts as a read
	always_comb begin
		logic [2:0] cur_cmd;
		cur_cmd  = (state_ff == nsr_pkg::S_IDLE) ? AVS_WRITEDATA_IN[2:0] : cmd_ff;
		nxt_pins = nsr_pkg::PINS_IDLE;
		if (nxt_state == nsr_pkg::S_ACC) begin
			nxt_pins.ce_n = 1'b0;
			if (cur_cmd != nsr_pkg::CMD_WRITE) begin
				nxt_pins.oe_n = 1'b0; // we_n stays high
			end else begin
				nxt_pins.we_n  = 1'b0;
				nxt_pins.dq    = wdata_ff;
				nxt_pins.dq_oe = 1'b1;
			end
			if (cur_cmd >= nsr_pkg::CMD_SW_STORE)
				nxt_pins.addr = {1'b0, seq_addr(nxt_idx, cur_cmd)};
			else
				nxt_pins.addr = addr_ff;
			nxt_pins.upper_byte_enable_n = !be_ff[1];
			nxt_pins.lower_byte_enable_n = !be_ff[0];
		end
	end

	// state, counter, pins
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_ff <= nsr_pkg::S_IDLE;
			cnt_ff   <= '0;
			idx_ff   <= '0;
			pins_ff  <= nsr_pkg::PINS_IDLE; // write enable inactive from reset
		end else if (CLK_EN_IN) begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			idx_ff   <= nxt_idx;
			pins_ff  <= nxt_pins;
		end
	end
	assign SRAM_PINS_OUT       = pins_ff;
	assign STORE_BUSY_N_OUT    = 1'b0;
	assign STORE_BUSY_N_OE_OUT = state_ff == nsr_pkg::S_PULL; // released after the pulse

	// read capture, done flag, power-loss store shadow
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rdata_ff   <= '0;
			done_ff    <= 1'b0;
			pls_en_ff  <= nsr_pkg::PLS_EN_RESET;
			unsaved_ff <= 1'b0;
		end else if (CLK_EN_IN) begin
			if (state_ff == nsr_pkg::S_ACC && cnt_ff == '0 && !pins_ff.oe_n)
				rdata_ff <= dq_s_ff;
			if (cmd_go)
				done_ff <= 1'b0;
			else if (state_ff != nsr_pkg::S_IDLE && nxt_state == nsr_pkg::S_IDLE)
				done_ff <= 1'b1;
			if (state_ff == nsr_pkg::S_GAP && nxt_state == nsr_pkg::S_WAIT) begin
				if (cmd_ff == nsr_pkg::CMD_PLS_DISABLE || cmd_ff == nsr_pkg::CMD_PLS_ENABLE) begin
					pls_en_ff  <= cmd_ff == nsr_pkg::CMD_PLS_ENABLE;
					unsaved_ff <= 1'b1; // store still needed
				end else if (cmd_ff == nsr_pkg::CMD_SW_STORE)
					unsaved_ff <= 1'b0;
			end
			if (state_ff == nsr_pkg::S_PULL)
				unsaved_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN || !CLK_EN_IN);
	sequence s_pull_start;
		$rose(STORE_BUSY_N_OE_OUT);
	endsequence
	sequence s_released;
		!STORE_BUSY_N_OE_OUT;
	endsequence

	a_seq_we_high: assert property (is_seq && !pins_ff.ce_n |-> pins_ff.we_n)
		else $error("write enable low during sequence read");
	a_seq_no_write: assert property (is_seq && state_ff != nsr_pkg::S_IDLE |-> !pins_ff.dq_oe)
		else $error("data driven inside sequence");
	a_seq_first_addr: assert property (is_seq && idx_ff == 3'h0 && !pins_ff.ce_n
		|-> pins_ff.addr[15:0] == nsr_pkg::SEQ_A0)
		else $error("wrong first sequence address");
	a_seq_order: assert property (is_seq && $rose(idx_ff == 3'h4) ##1 (!pins_ff.ce_n)[*1]
		|-> pins_ff.addr[15:0] == nsr_pkg::SEQ_A4)
		else $error("sequence step out of order");
	a_recall_code: assert property (cmd_ff == nsr_pkg::CMD_SW_RECALL && idx_ff == 3'h5 && !pins_ff.ce_n
		|-> pins_ff.addr[15:0] == nsr_pkg::FIN_RECALL)
		else $error("wrong recall code");
	a_disable_code: assert property (cmd_ff == nsr_pkg::CMD_PLS_DISABLE && idx_ff == 3'h5 && !pins_ff.ce_n
		|-> pins_ff.addr[15:0] == nsr_pkg::FIN_DISABLE && !pins_ff.oe_n)
		else $error("wrong disable code");
	a_enable_code: assert property (cmd_ff == nsr_pkg::CMD_PLS_ENABLE && idx_ff == 3'h5 && !pins_ff.ce_n
		|-> pins_ff.addr[15:0] == nsr_pkg::FIN_ENABLE)
		else $error("wrong enable code");
	a_pull_released: assert property (s_pull_start |-> ##[1:300] s_released)
		else $error("store request pin never released");
	a_hold_access: assert property ($fell(pins_ff.ce_n) |-> $past(busy_s_ff, 2))
		else $error("access started while busy");
endmodule : nsr_host_ctrl
`default_nettype wire

// file: logic/nsr_pkg.sv
`default_nettype none
package nsr_pkg;
	// ----------------------------------------
	// pin widths and sram pin carrier
	// ----------------------------------------
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic              dq_oe;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              upper_byte_enable_n;
		logic              lower_byte_enable_n;
	} nsr_sram_out_t;
	localparam nsr_sram_out_t PINS_IDLE = '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
		we_n: 1'b1, upper_byte_enable_n: 1'b1, lower_byte_enable_n: 1'b1};
	// ----------------------------------------
	// register map (word index on the avalon address)
	// ----------------------------------------
	localparam logic [2:0] REG_CMD    = 3'h0;
	localparam logic [2:0] REG_ADDR   = 3'h1;
	localparam logic [2:0] REG_WDATA  = 3'h2;
	localparam logic [2:0] REG_RDATA  = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;
	localparam int WDATA_BE_POS   = 16;
	localparam int ST_BUSY_POS    = 0;
	localparam int ST_PIN_POS     = 1;
	localparam int ST_DONE_POS    = 2;
	localparam int ST_PLS_EN_POS  = 3;
	localparam int ST_UNSAVED_POS = 4;
	localparam logic PLS_EN_RESET = 1'b1;
	// ----------------------------------------
	// commands
	// ----------------------------------------
	localparam logic [2:0] CMD_READ        = 3'h1;
	localparam logic [2:0] CMD_WRITE       = 3'h2;
	localparam logic [2:0] CMD_SW_STORE    = 3'h3;
	localparam logic [2:0] CMD_SW_RECALL   = 3'h4;
	localparam logic [2:0] CMD_PLS_DISABLE = 3'h5;
	localparam logic [2:0] CMD_PLS_ENABLE  = 3'h6;
	localparam logic [2:0] CMD_HW_STORE    = 3'h7;
	// ----------------------------------------
	// command sequence addresses
	// ----------------------------------------
	localparam logic [15:0] SEQ_A0      = 16'h4E38;
	localparam logic [15:0] SEQ_A1      = 16'hB1C7;
	localparam logic [15:0] SEQ_A2      = 16'h83E0;
	localparam logic [15:0] SEQ_A3      = 16'h7C1F;
	localparam logic [15:0] SEQ_A4      = 16'h703F;
	localparam logic [15:0] FIN_STORE   = 16'h8FC0;
	localparam logic [15:0] FIN_RECALL  = 16'h4C63;
	localparam logic [15:0] FIN_DISABLE = 16'h8B45;
	localparam logic [15:0] FIN_ENABLE  = 16'h4B46;
	localparam logic [2:0]  SEQ_LAST    = 3'h5;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS          = 4;
	localparam int SYNC_STAGES            = 2;
	localparam int T_ACCESS_NS            = 25;
	localparam int T_RECOVER_NS           = 8;
	localparam int T_STORE_START_DELAY_NS = 25;
	localparam int T_POST_BUSY_HOLD_NS    = 20;
	localparam int T_REQUEST_PULSE_NS     = 20;
	localparam int CNT_W                  = 12;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_DELAY_CYC = (T_STORE_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
	localparam int POST_BUSY_HOLD_CYC = (T_POST_BUSY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REQUEST_PULSE_CYC = (T_REQUEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------
	// engine states
	// ----------------------------------------
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_ACC  = 6'h02,
		S_GAP  = 6'h04,
		S_PULL = 6'h08,
		S_WAIT = 6'h10,
		S_HOLD = 6'h20
	} nsr_state_t;
endpackage : nsr_pkg
`default_nettype wire

// file: test/nsr_sram_model.sv
`timescale 1ns/1ns
`default_nettype none
module nsr_sram_model #(
	parameter int STORE_CYC_P  = 30,
	parameter int RECALL_CYC_P = 40,
	parameter int DELAY_CYC_P  = 3,
	parameter int HOLD_CYC_P   = 5
) (
	// clock and core supply good
	input  wire logic                   clk_in,
	input  wire logic                   power_ok_in,
	// sram pins and busy wire level
	input  wire nsr_pkg::nsr_sram_out_t pins_in,
	input  wire logic                   busy_wire_in,
	output logic [15:0]                 dq_out,
	output logic                        busy_pull_out,
	// observation for the bench
	output int                          store_cnt_out,
	output int                          recall_cnt_out,
	output int                          viol_cnt_out,
	output logic                        pls_en_out
);
	logic [15:0]            mem [256];
	logic [15:0]            nv [256];
	nsr_pkg::nsr_sram_out_t prev_ff;
	logic [2:0]             step_ff;
	logic                   latch_ff;
	logic                   busy_prev_ff;
	logic                   rec_ff;
	int                     busy_cnt_ff;
	int                     pend_ff;
	int                     hold_ff;
	logic [12:0]            key;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// only address bits 14..2 take part in matching
	function automatic logic [12:0] seq_key(input logic [2:0] s);
		case (s)
			3'h0: return nsr_pkg::SEQ_A0[14:2];
			3'h1: return nsr_pkg::SEQ_A1[14:2];
			3'h2: return nsr_pkg::SEQ_A2[14:2];
			3'h3: return nsr_pkg::SEQ_A3[14:2];
			default: return nsr_pkg::SEQ_A4[14:2];
		endcase
	endfunction : seq_key
	// erase then program the shadow, busy held low until done
	task automatic do_store;
		for (int i = 0; i < 256; i++)
			nv[i] = mem[i];
		latch_ff      <= 1'b0;
		store_cnt_out <= store_cnt_out + 1;
		busy_cnt_ff   <= STORE_CYC_P;
	endtask : do_store
	// clear and reload sram, shadow untouched
	task automatic do_recall;
		for (int i = 0; i < 256; i++)
			mem[i] = nv[i];
		latch_ff       <= 1'b0;
		recall_cnt_out <= recall_cnt_out + 1;
		busy_cnt_ff    <= STORE_CYC_P;
	endtask : do_recall

	// ----------------------------------------
	// shipped state and busy driver
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 256; i++)
			nv[i] = 16'h0000;
		pls_en_out     = 1'b1;
		latch_ff       = 1'b0;
		store_cnt_out  = 0;
		recall_cnt_out = 0;
		viol_cnt_out   = 0;
	end
	// model only pulls the pin low while busy, never drives it high; the pull-up keeps it high otherwise
	assign busy_pull_out = busy_cnt_ff > 0;

	// ----------------------------------------
	// device behaviour
	// ----------------------------------------
	always @(posedge clk_in or negedge power_ok_in) begin
		if (!power_ok_in) begin
			// supply low: no writes land, armed power-loss store, recall latched
			if (pls_en_out && latch_ff) begin
				for (int i = 0; i < 256; i++)
					nv[i] = mem[i];
			end
			for (int i = 0; i < 256; i++)
				mem[i] = nv[i];
			latch_ff     <= 1'b0;
			step_ff      <= 3'h0;
			rec_ff       <= 1'b1;
			busy_cnt_ff  <= RECALL_CYC_P;
			pend_ff      <= 0;
			hold_ff      <= 0;
			prev_ff      <= nsr_pkg::PINS_IDLE;
			busy_prev_ff <= 1'b0;
			dq_out       <= 16'hA5A5;
		end else begin
			prev_ff      <= pins_in;
			busy_prev_ff <= busy_wire_in;
			if (rec_ff) begin
				recall_cnt_out <= recall_cnt_out + 1;
				rec_ff         <= 1'b0;
			end
			if (busy_cnt_ff > 0)
				busy_cnt_ff <= busy_cnt_ff - 1;
			// access start while busy or inside post-busy hold
			if (prev_ff.ce_n && !pins_in.ce_n && (!busy_wire_in || hold_ff > 0))
				viol_cnt_out <= viol_cnt_out + 1;
			// end of an access decides write or sequence step
			if (!prev_ff.ce_n && pins_in.ce_n) begin
				key = prev_ff.addr[14:2];
				if (!prev_ff.we_n) begin
					if (!prev_ff.upper_byte_enable_n)
						mem[prev_ff.addr[7:0]][15:8] = prev_ff.dq[15:8];
					if (!prev_ff.lower_byte_enable_n)
						mem[prev_ff.addr[7:0]][7:0] = prev_ff.dq[7:0];
					latch_ff <= 1'b1;
					step_ff  <= 3'h0;
				end else if (!prev_ff.oe_n && step_ff == nsr_pkg::SEQ_LAST) begin
					step_ff <= 3'h0;
					case (key)
						nsr_pkg::FIN_STORE[14:2]: do_store();
						nsr_pkg::FIN_RECALL[14:2]: do_recall();
						nsr_pkg::FIN_DISABLE[14:2]: pls_en_out <= 1'b0;
						nsr_pkg::FIN_ENABLE[14:2]: pls_en_out <= 1'b1;
						default: step_ff <= (key == seq_key(3'h0)) ? 3'h1 : 3'h0;
					endcase
				end else if (!prev_ff.oe_n) begin
					step_ff <= (key == seq_key(step_ff)) ? step_ff + 3'h1 :
						((key == seq_key(3'h0)) ? 3'h1 : 3'h0);
				end
			end
			// outside pull of busy: store after the start delay, only if armed
			if (busy_prev_ff && !busy_wire_in && busy_cnt_ff == 0 && pend_ff == 0 && latch_ff)
				pend_ff <= DELAY_CYC_P;
			else if (pend_ff > 0)
				pend_ff <= pend_ff - 1;
			if (pend_ff == 1)
				do_store();
			// post-busy access hold
			if (!busy_prev_ff && busy_wire_in)
				hold_ff <= HOLD_CYC_P;
			else if (hold_ff > 0)
				hold_ff <= hold_ff - 1;
			// read data, otherwise a changing pattern
			if (!pins_in.ce_n && !pins_in.oe_n && pins_in.we_n && busy_wire_in && busy_cnt_ff == 0)
				dq_out <= mem[pins_in.addr[7:0]];
			else
				dq_out <= ~dq_out;
		end
	end
endmodule : nsr_sram_model
`default_nettype wire

// file: test/test_nsr_host_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_nsr_host_ctrl;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   clk_en = 1'b1;
	logic [2:0]             av_addr = 3'h0;
	logic                   av_rd = 1'b0;
	logic                   av_wr = 1'b0;
	logic [31:0]            av_wdata = 32'h0;
	logic [31:0]            av_rdata;
	logic                   av_wait;
	nsr_pkg::nsr_sram_out_t pins;
	logic [15:0]            dq;
	logic                   busy_val;
	logic                   busy_oe;
	logic                   model_pull;
	logic                   busy_wire;
	int                     store_cnt;
	int                     recall_cnt;
	int                     viol_cnt;
	logic                   pls_en;
	logic [15:0]            ref_mem [256];
	logic [7:0]             addrs [8];
	logic [31:0]            q;
	int                     fails = 0;
	int                     num_checks = 0;
	int                     seed = 52;

	// ----------------------------------------
	// clock, wire, instances
	// ----------------------------------------
	always #2 clk = ~clk;
	// open-drain busy wire with pull-up
	assign busy_wire = !((busy_oe && !busy_val) || model_pull);
	nsr_host_ctrl nsr_host_ctrl_i (.CLK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(clk_en),
		.AVS_ADDRESS_IN(av_addr), .AVS_READ_IN(av_rd), .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wdata),
		.AVS_READDATA_OUT(av_rdata), .AVS_WAITREQUEST_OUT(av_wait), .SRAM_PINS_OUT(pins), .DQ_IN(dq),
		.STORE_BUSY_N_IN(busy_wire), .STORE_BUSY_N_OUT(busy_val), .STORE_BUSY_N_OE_OUT(busy_oe));
	nsr_sram_model nsr_sram_model_i (.clk_in(clk), .power_ok_in(rst_n), .pins_in(pins),
		.busy_wire_in(busy_wire), .dq_out(dq), .busy_pull_out(model_pull), .store_cnt_out(store_cnt),
		.recall_cnt_out(recall_cnt), .viol_cnt_out(viol_cnt), .pls_en_out(pls_en));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// expected word after a byte-masked write
	function automatic logic [15:0] merge_word(input logic [15:0] old, input logic [15:0] d, input logic [1:0] be);
		return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction : merge_word
	// one avalon transfer, held until waitrequest is seen low
	task automatic av_xfer(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		av_addr  <= a;
		av_wr    <= wr;
		av_rd    <= !wr;
		av_wdata <= d;
		@(posedge clk);
		while (av_wait !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000)
			fails++;
		r = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
		@(posedge clk);
	endtask : av_xfer
	// issue a command and poll the done flag
	task automatic run_cmd(input logic [2:0] c);
		logic [31:0] r;
		int          n;
		av_xfer(1'b1, nsr_pkg::REG_CMD, {29'h0, c}, r);
		n = 0;
		r = 32'h0;
		while (r[nsr_pkg::ST_DONE_POS] !== 1'b1 && n < 500) begin
			av_xfer(1'b0, nsr_pkg::REG_STATUS, 32'h0, r);
			n++;
		end
		check("cmd_done", 32'h1, {31'h0, r[nsr_pkg::ST_DONE_POS]});
	endtask : run_cmd
	task automatic sram_write(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
		av_xfer(1'b1, nsr_pkg::REG_ADDR, {24'h0, a}, q);
		av_xfer(1'b1, nsr_pkg::REG_WDATA, {14'h0, be, d}, q);
		run_cmd(nsr_pkg::CMD_WRITE);
		ref_mem[a] = merge_word(ref_mem[a], d, be);
	endtask : sram_write
	task automatic sram_check(input logic [7:0] a);
		av_xfer(1'b1, nsr_pkg::REG_ADDR, {24'h0, a}, q);
		run_cmd(nsr_pkg::CMD_READ);
		av_xfer(1'b0, nsr_pkg::REG_RDATA, 32'h0, q);
		check("sram_data", {16'h0, ref_mem[a]}, {16'h0, q[15:0]});
	endtask : sram_check
	task automatic status_bit(input string what, input int pos, input logic exp);
		av_xfer(1'b0, nsr_pkg::REG_STATUS, 32'h0, q);
		check(what, {31'h0, exp}, {31'h0, q[pos]});
	endtask : status_bit

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		foreach (ref_mem[i])
			ref_mem[i] = 16'h0000;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		status_bit("pls_enabled", nsr_pkg::ST_PLS_EN_POS, 1'b1);
		check("recall_count", 32'd1, 32'(recall_cnt));
		run_cmd(nsr_pkg::CMD_HW_STORE);
		check("store_count", 32'd0, 32'(store_cnt));
		foreach (addrs[i]) begin
			addrs[i] = 8'($random(seed));
			sram_write(addrs[i], 16'($random(seed)), 2'($random(seed)));
		end
		foreach (addrs[i])
			sram_check(addrs[i]);
		run_cmd(nsr_pkg::CMD_HW_STORE);
		check("store_count", 32'd1, 32'(store_cnt));
		run_cmd(nsr_pkg::CMD_SW_STORE);
		run_cmd(nsr_pkg::CMD_SW_STORE);
		check("store_count", 32'd3, 32'(store_cnt));
		sram_write(addrs[0], ~ref_mem[addrs[0]], 2'h3);
		sram_write(addrs[0], ~ref_mem[addrs[0]], 2'h3);
		sram_write(addrs[1], ~ref_mem[addrs[1]], 2'h3);
		run_cmd(nsr_pkg::CMD_SW_RECALL);
		ref_mem[addrs[1]] = ~ref_mem[addrs[1]];
		sram_check(addrs[1]);
		check("recall_count", 32'd2, 32'(recall_cnt));
		run_cmd(nsr_pkg::CMD_PLS_DISABLE);
		check("pls_model", 32'd0, {31'h0, pls_en});
		status_bit("pls_enabled", nsr_pkg::ST_PLS_EN_POS, 1'b0);
		status_bit("unsaved", nsr_pkg::ST_UNSAVED_POS, 1'b1);
		run_cmd(nsr_pkg::CMD_PLS_ENABLE);
		check("pls_model", 32'd1, {31'h0, pls_en});
		run_cmd(nsr_pkg::CMD_SW_STORE);
		status_bit("unsaved", nsr_pkg::ST_UNSAVED_POS, 1'b0);
		av_xfer(1'b0, 3'h7, 32'h0, q);
		check("unmapped_read", 32'h0, q);
		// frozen clock enable keeps a read unanswered
		clk_en <= 1'b0;
		fork
			av_xfer(1'b0, nsr_pkg::REG_STATUS, 32'h0, q);
			begin
				repeat (3) @(posedge clk);
				check("frozen_wait", 32'h1, {31'h0, av_wait});
				clk_en <= 1'b1;
			end
		join
		check("engine_busy", 32'h0, {31'h0, q[nsr_pkg::ST_BUSY_POS]});
		check("busy_pin", 32'h1, {31'h0, q[nsr_pkg::ST_PIN_POS]});
		sram_write(addrs[2], 16'h5AC3, 2'h3);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		sram_check(addrs[2]);
		check("recall_count", 32'd3, 32'(recall_cnt));
		check("blocked_access", 32'd0, 32'(viol_cnt));
		give_verdict();
	end
	// watchdog
	initial begin
		#120000;
		fails++;
		give_verdict();
	end
endmodule : test_nsr_host_ctrl
`default_nettype wire
